// ### logic/pscp_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "pscp_regs.svh"
module pscp_device
   import pscp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   pscp_if.device           link,
   input  wire logic        phase_up_pulse,
   input  wire logic        phase_down_pulse,
   output logic [19:0]      secondary_word,
   output logic [19:0]      staging_word,
   output logic [7:0]       ext_word_eff,
   output logic             freq_sel_applied,
   output logic             nv_select_level,
   output logic             lock_filter_node,
   output logic             locked
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic             sclk_prev;
   logic             strobe_prev;

   assign pin_raw = {link.sclk, link.sdata, link.load_strobe, link.ext_wr_en,
                     link.nv_load_control, link.nv_select_control,
                     link.extended_mode_n, link.freq_reg_select};

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= 8'h06;
         sync_b <= 8'h06;
      end else begin
         sync_a <= pin_raw;
         sync_b <= sync_a;
      end
   end

   logic s_sclk, s_sdata, s_strobe, s_ewr, s_nvload, s_nvsel, s_extn, s_freq_reg_select;
   assign {s_sclk, s_sdata, s_strobe, s_ewr, s_nvload, s_nvsel, s_extn, s_freq_reg_select} = sync_b;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_prev   <= 1'b0;
         strobe_prev <= 1'b0;
      end else begin
         sclk_prev   <= s_sclk;
         strobe_prev <= s_strobe;
      end
   end

   logic sclk_rise;
   logic strobe_rise;
   assign sclk_rise   = s_sclk & ~sclk_prev;
   assign strobe_rise = s_strobe & ~strobe_prev;

   // ----------------------------------------
   // target decode
   // ----------------------------------------
   pscp_target_e target;
   always_comb begin
      if (s_ewr) begin
         target = PSCP_TGT_EXTENDED;
      end else if (s_nvload) begin
         target = PSCP_TGT_STAGING;
      end else begin
         target = PSCP_TGT_PRIMARY;
      end
   end

   // ----------------------------------------
   // shift registers
   // ----------------------------------------
   logic [19:0] primary;
   logic [19:0] staging;
   logic [7:0]  extended;

   // first bit in ends up at bit zero after a full word
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         primary <= `PSCP_PRI_RST;
      end else if (sclk_rise && target == PSCP_TGT_PRIMARY) begin
         primary <= {s_sdata, primary[19:1]};
      end
   end

   // staging shifts out at bit zero while shifting in at the top
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         staging <= `PSCP_STG_RST;
      end else if (sclk_rise) begin
         if (target == PSCP_TGT_STAGING) begin
            staging <= {s_sdata, staging[19:1]};
         end else begin
            staging <= {staging[0], staging[19:1]};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extended <= `PSCP_EXT_RST;
      end else if (sclk_rise && target == PSCP_TGT_EXTENDED) begin
         extended <= {s_sdata, extended[7:1]};
      end
   end

   // ----------------------------------------
   // secondary register
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         secondary_word <= `PSCP_SEC_RST;
      end else if (strobe_rise) begin
         secondary_word <= primary;
      end
   end

   // ----------------------------------------
   // mode outputs
   // ----------------------------------------
   logic [7:0] next_ext_eff;
   assign next_ext_eff = s_extn ? `PSCP_EXT_RST : extended;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ext_word_eff     <= `PSCP_EXT_RST;
         staging_word     <= `PSCP_STG_RST;
         freq_sel_applied <= 1'b0;
         nv_select_level  <= 1'b1;
      end else begin
         ext_word_eff     <= next_ext_eff;
         staging_word     <= staging;
         freq_sel_applied <= s_freq_reg_select;
         nv_select_level  <= s_nvsel;
      end
   end

   // ----------------------------------------
   // lock detect
   // ----------------------------------------
   localparam int LOCK_CYC = `PSCP_LOCK_FILT_CYC;
   logic [7:0] filt_cnt;
   logic       up_a, up_b, dn_a, dn_b;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         up_a <= 1'b0;
         up_b <= 1'b0;
         dn_a <= 1'b0;
         dn_b <= 1'b0;
      end else begin
         up_a <= phase_up_pulse;
         up_b <= up_a;
         dn_a <= phase_down_pulse;
         dn_b <= dn_a;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lock_filter_node <= 1'b0;
      end else begin
         lock_filter_node <= ~(up_b & dn_b);
      end
   end

   // low-pass: node must stay high for the filter time
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         filt_cnt <= 8'h00;
         locked   <= 1'b0;
      end else if (!lock_filter_node) begin
         filt_cnt <= 8'h00;
         locked   <= 1'b0;
      end else if (filt_cnt == 8'(LOCK_CYC - 1)) begin
         locked   <= 1'b1;
      end else begin
         filt_cnt <= filt_cnt + 8'h01;
      end
   end

   // open drain: drive low only while unlocked
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         link.lock_o  <= 1'b0;
         link.lock_oe <= 1'b1;
      end else begin
         link.lock_o  <= 1'b0;
         link.lock_oe <= ~locked;
      end
   end

   // ----------------------------------------
   // data output
   // ----------------------------------------
   pscp_dsel_e dsel;
   logic       next_dout;
   assign dsel = pscp_dsel_e'(extended[`PSCP_EXT_DSEL_MSB:`PSCP_EXT_DSEL_LSB]);

   always_comb begin
      case (dsel)
         PSCP_DSEL_STAGING: next_dout = staging[0];
         PSCP_DSEL_LOCK:    next_dout = locked;
         PSCP_DSEL_FREQ_REG_SELECT:    next_dout = s_freq_reg_select;
         default:           next_dout = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         link.dout_o  <= 1'b0;
         link.dout_oe <= 1'b0;
      end else begin
         link.dout_o  <= next_dout;
         link.dout_oe <= ~s_extn;
      end
   end

endmodule
`default_nettype wire

// ### logic/pscp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pscp_regs.svh"
module pscp_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   logic [AW:0]      next_count;

   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count    <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count    <= next_count;
         in_ready <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule

module pscp_host
   import pscp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   pscp_if.host             link,
   input  wire pscp_cmd_s   cmd,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        freq_reg_select_req,
   input  wire logic        ext_mode_req,
   input  wire logic        nv_select_req,
   output logic [19:0]      rd_word,
   output logic             rd_valid,
   output logic             lock_seen,
   output logic             busy
);
   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_STROBE} pscp_hstate_e;

   localparam int HALF = `PSCP_SCLK_HALF_CYC;
   pscp_cmd_s    cur;
   logic         f_valid;
   logic         f_ready;
   pscp_cmd_s    f_data;
   pscp_hstate_e state;
   logic [4:0]   bit_idx;
   logic [4:0]   last_idx;
   logic [7:0]   div;
   logic         tick;
   logic [19:0]  rx;
   logic         d_a, d_b, l_a, l_b;

   pscp_fifo #(.WIDTH($bits(pscp_cmd_s)), .DEPTH(8)) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_data   (cmd),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   assign f_ready  = (state == H_IDLE);
   assign tick     = (div == 8'(HALF - 1));
   assign last_idx = (cur.target == PSCP_TGT_EXTENDED) ? 5'h07 : 5'h13;

   // ----------------------------------------
   // divider and pin sync
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div <= 8'h00;
      end else if (state == H_IDLE || tick) begin
         div <= 8'h00;
      end else begin
         div <= div + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         d_a <= 1'b0;
         d_b <= 1'b0;
         l_a <= 1'b0;
         l_b <= 1'b0;
      end else begin
         d_a <= link.dout;
         d_b <= d_a;
         l_a <= link.lock_indicator;
         l_b <= l_a;
      end
   end

   // ----------------------------------------
   // static control lines
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         link.freq_reg_select_o            <= 1'b0;
         link.freq_reg_select_oe           <= 1'b0;
         link.extended_mode_n   <= 1'b1;
         link.nv_select_control <= 1'b1;
         lock_seen              <= 1'b0;
      end else begin
         link.freq_reg_select_o            <= freq_reg_select_req;
         link.freq_reg_select_oe           <= 1'b1;
         link.extended_mode_n   <= ~ext_mode_req;
         link.nv_select_control <= nv_select_req;
         lock_seen              <= l_b;
      end
   end

   // ----------------------------------------
   // transfer sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state                <= H_IDLE;
         cur                  <= '0;
         bit_idx              <= 5'h00;
         rx                   <= 20'h00000;
         rd_word              <= 20'h00000;
         rd_valid             <= 1'b0;
         busy                 <= 1'b0;
         link.sclk            <= 1'b0;
         link.sdata           <= 1'b0;
         link.load_strobe     <= 1'b0;
         link.ext_wr_en       <= 1'b0;
         link.nv_load_control <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         case (state)
            H_IDLE: begin
               busy <= 1'b0;
               if (f_valid) begin
                  cur                  <= f_data;
                  bit_idx              <= 5'h00;
                  busy                 <= 1'b1;
                  link.sdata           <= f_data.data[0];
                  link.ext_wr_en       <= (f_data.target == PSCP_TGT_EXTENDED);
                  link.nv_load_control <= (f_data.target == PSCP_TGT_STAGING);
                  state                <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick) begin
                  link.sclk <= ~link.sclk;
                  if (!link.sclk) begin
                     rx <= {d_b, rx[19:1]};
                  end else if (bit_idx == last_idx) begin
                     state <= H_STROBE;
                  end else begin
                     bit_idx    <= bit_idx + 5'h01;
                     link.sdata <= cur.data[bit_idx + 5'h01];
                  end
               end
            end
            default: begin
               if (tick) begin
                  if (cur.target == PSCP_TGT_PRIMARY && !link.load_strobe) begin
                     link.load_strobe <= 1'b1;
                  end else begin
                     link.load_strobe     <= 1'b0;
                     link.ext_wr_en       <= 1'b0;
                     link.nv_load_control <= 1'b0;
                     rd_word              <= rx;
                     rd_valid             <= 1'b1;
                     state                <= H_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### logic/pscp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pscp_if;
   logic sclk;
   logic sdata;
   logic load_strobe;
   logic ext_wr_en;
   logic nv_load_control;
   logic nv_select_control;
   logic extended_mode_n;
   logic freq_reg_select_o;
   logic freq_reg_select_oe;
   logic freq_reg_select;
   logic dout_o;
   logic dout_oe;
   logic dout;
   logic lock_o;
   logic lock_oe;
   logic lock_indicator;

   // pull-down on select, pull-up on lock pin, weak low on idle output
   assign freq_reg_select = freq_reg_select_oe ? freq_reg_select_o : 1'b0;
   assign lock_indicator  = lock_oe ? lock_o : 1'b1;
   assign dout            = dout_oe ? dout_o : 1'b0;

   modport device (
      input  sclk, sdata, load_strobe, ext_wr_en, nv_load_control,
             nv_select_control, extended_mode_n, freq_reg_select, lock_indicator,
      output dout_o, dout_oe, lock_o, lock_oe
   );
   modport host (
      input  dout, lock_indicator,
      output sclk, sdata, load_strobe, ext_wr_en, nv_load_control,
             nv_select_control, extended_mode_n, freq_reg_select_o, freq_reg_select_oe
   );
endinterface
`default_nettype wire

// ### logic/pscp_pkg.sv
`default_nettype none
package pscp_pkg;
   typedef enum logic [1:0] {
      PSCP_TGT_PRIMARY,
      PSCP_TGT_STAGING,
      PSCP_TGT_EXTENDED
   } pscp_target_e;

   typedef enum logic [1:0] {
      PSCP_DSEL_STAGING,
      PSCP_DSEL_LOCK,
      PSCP_DSEL_FREQ_REG_SELECT,
      PSCP_DSEL_ZERO
   } pscp_dsel_e;

   typedef struct packed {
      pscp_target_e target;
      logic [19:0]  data;
   } pscp_cmd_s;
endpackage
`default_nettype wire

// ### logic/pscp_regs.svh
// How it works
// - load strobe rise copies primary into secondary
// - words go least significant bit first
// - each serial clock rise shifts selected register
// - staging register shifts out on data output
// - extended register written only with enable high
// - extended bits act only while mode low
// - extended bits pick output; enabled by mode
// - lock pin pulled low when out of lock
// - filter node is nand of up, down
// - undriven frequency select reads as low
// - host steers targets with extended write enable and nv load control lines
`ifndef PSCP_REGS_SVH
`define PSCP_REGS_SVH

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define PSCP_MAIN_W        20
`define PSCP_EXT_W         8
`define PSCP_PRI_RST       20'h00000
`define PSCP_SEC_RST       20'h00000
`define PSCP_STG_RST       20'h00000
`define PSCP_EXT_RST       8'h00

// ----------------------------------------
// extended register fields
// ----------------------------------------
`define PSCP_EXT_DSEL_LSB  0
`define PSCP_EXT_DSEL_MSB  1

// ----------------------------------------
// timing
// ----------------------------------------
`define PSCP_CLK_NS        10
`define PSCP_SCLK_HALF_NS  80
`define PSCP_SCLK_HALF_CYC (`PSCP_SCLK_HALF_NS / `PSCP_CLK_NS)
`define PSCP_LOCK_FILT_NS  500
`define PSCP_LOCK_FILT_CYC ((`PSCP_LOCK_FILT_NS + `PSCP_CLK_NS - 1) / `PSCP_CLK_NS)

`endif

// ### tb/pscp_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// link checker
// ----------------------------------------
module pscp_link_chk (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic load_strobe,
   input wire logic ext_wr_en,
   input wire logic nv_load_control,
   input wire logic extended_mode_n,
   input wire logic dout_oe,
   input wire logic lock_o,
   input wire logic lock_oe,
   input wire logic lock_indicator
);
   logic [4:0] cnt;
   logic       sclk_q;
   logic       ext_q;
   logic       nv_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // ----------------------------------------
   // helper: serial clock rises per frame
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q <= 1'b0;
         ext_q  <= 1'b0;
         nv_q   <= 1'b0;
      end else begin
         sclk_q <= sclk;
         ext_q  <= ext_wr_en;
         nv_q   <= nv_load_control;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 5'h00;
      end else if (load_strobe || (ext_q && !ext_wr_en) || (nv_q && !nv_load_control)) begin
         cnt <= 5'h00;
      end else if (sclk && !sclk_q) begin
         cnt <= cnt + 5'h01;
      end
   end

   // ----------------------------------------
   // sequences and assertions
   // ----------------------------------------
   sequence sclk_hold_s;
      sclk [*7];
   endsequence
   sequence strobe_hold_s;
      load_strobe [*7];
   endsequence

   sclk_high_a: assert property ($rose(sclk) |=> sclk_hold_s)
      else $error("serial clock high phase too short");
   data_hold_a: assert property ($rose(sclk) |-> $stable(sdata) ##1 $stable(sdata) [*6])
      else $error("serial data moved around clock rise");
   strobe_len_a: assert property ($rose(load_strobe) |=> strobe_hold_s)
      else $error("load strobe too short");
   strobe_frame_a: assert property ($rose(load_strobe) |-> cnt == 5'h14)
      else $error("load strobe not after twenty bits");
   strobe_idle_a: assert property (load_strobe |-> !sclk && !ext_wr_en)
      else $error("load strobe during shifting");
   ext_count_a: assert property ($fell(ext_wr_en) |-> cnt == 5'h08)
      else $error("extended frame not eight bits");
   stage_count_a: assert property ($fell(nv_load_control) |-> cnt == 5'h14)
      else $error("staging frame not twenty bits");
   target_one_a: assert property (ext_wr_en |-> !nv_load_control)
      else $error("two targets selected");
   dout_gate_a: assert property (extended_mode_n [*5] |-> !dout_oe)
      else $error("data output enabled outside extended mode");
   lock_drain_a: assert property (lock_oe |-> !lock_o && !lock_indicator)
      else $error("lock pin driven high");
endmodule
`default_nettype wire

// ### tb/tb_pll_serial_config_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pll_serial_config_port
   import pscp_pkg::*;
;
   typedef struct packed {
      pscp_target_e tgt;
      logic [19:0]  data;
      logic         mode;
      logic [19:0]  exp;
      logic         rd;
      logic [19:0]  rexp;
   } pscp_row_s;

   logic        clk_sys;
   logic        rst_b;
   logic        phase_up_pulse;
   logic        phase_down_pulse;
   logic [19:0] secondary_word;
   logic [19:0] staging_word;
   logic [7:0]  ext_word_eff;
   logic        freq_sel_applied;
   logic        nv_select_level;
   logic        lock_filter_node;
   logic        locked;
   pscp_cmd_s   cmd;
   logic        cmd_valid;
   logic        cmd_ready;
   logic        freq_reg_select_req;
   logic        ext_mode_req;
   logic        nv_select_req;
   logic [19:0] rd_word;
   logic        rd_valid;
   logic        lock_seen;
   logic        busy;
   logic [19:0] exp_sec;
   int          miscompares;
   int          tests_run;
   int          acc;
   int          rdn;
   pscp_row_s   rows [9] = '{
      '{PSCP_TGT_PRIMARY,  20'hA5C3F, 1'b0, 20'hA5C3F, 1'b0, 20'h00000},
      '{PSCP_TGT_PRIMARY,  20'h00001, 1'b0, 20'h00001, 1'b0, 20'h00000},
      '{PSCP_TGT_PRIMARY,  20'h80000, 1'b0, 20'h80000, 1'b0, 20'h00000},
      '{PSCP_TGT_EXTENDED, 20'h0005A, 1'b0, 20'h00000, 1'b0, 20'h00000},
      '{PSCP_TGT_EXTENDED, 20'h0003C, 1'b1, 20'h0003C, 1'b0, 20'h00000},
      '{PSCP_TGT_STAGING,  20'h12345, 1'b1, 20'h12345, 1'b0, 20'h00000},
      '{PSCP_TGT_PRIMARY,  20'h0F0F0, 1'b1, 20'h0F0F0, 1'b1, 20'h12345},
      '{PSCP_TGT_EXTENDED, 20'h00001, 1'b1, 20'h00001, 1'b0, 20'h00000},
      '{PSCP_TGT_PRIMARY,  20'h00F00, 1'b1, 20'h00F00, 1'b1, 20'hFFFFF}
   };

   pscp_if lnk ();

   pscp_device u_pscp_device (
      .clk_sys          (clk_sys),
      .rst_b            (rst_b),
      .link             (lnk),
      .phase_up_pulse   (phase_up_pulse),
      .phase_down_pulse (phase_down_pulse),
      .secondary_word   (secondary_word),
      .staging_word     (staging_word),
      .ext_word_eff     (ext_word_eff),
      .freq_sel_applied (freq_sel_applied),
      .nv_select_level  (nv_select_level),
      .lock_filter_node (lock_filter_node),
      .locked           (locked)
   );

   pscp_host u_pscp_host (
      .clk_sys       (clk_sys),
      .rst_b         (rst_b),
      .link          (lnk),
      .cmd           (cmd),
      .cmd_valid     (cmd_valid),
      .cmd_ready     (cmd_ready),
      .freq_reg_select_req      (freq_reg_select_req),
      .ext_mode_req  (ext_mode_req),
      .nv_select_req (nv_select_req),
      .rd_word       (rd_word),
      .rd_valid      (rd_valid),
      .lock_seen     (lock_seen),
      .busy          (busy)
   );

   pscp_link_chk u_pscp_link_chk (
      .clk_sys         (clk_sys),
      .rst_b           (rst_b),
      .sclk            (lnk.sclk),
      .sdata           (lnk.sdata),
      .load_strobe     (lnk.load_strobe),
      .ext_wr_en       (lnk.ext_wr_en),
      .nv_load_control (lnk.nv_load_control),
      .extended_mode_n (lnk.extended_mode_n),
      .dout_oe         (lnk.dout_oe),
      .lock_o          (lnk.lock_o),
      .lock_oe         (lnk.lock_oe),
      .lock_indicator  (lnk.lock_indicator)
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic send(input pscp_target_e tgt, input logic [19:0] data);
      @(negedge clk_sys);
      cmd       = '{tgt, data};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
   endtask

   task automatic wait_rd();
      int n;
      for (n = 0; n < 3000; n++) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1) break;
      end
      check("rd_valid", {19'h00000, rd_valid}, 20'h00001);
   endtask

   // ----------------------------------------
   // clock and watchdog
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      #200000;
      miscompares++;
      final_report();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_b            = 1'b0;
      phase_up_pulse   = 1'b0;
      phase_down_pulse = 1'b0;
      cmd              = '0;
      cmd_valid        = 1'b0;
      freq_reg_select_req         = 1'b0;
      ext_mode_req     = 1'b0;
      nv_select_req    = 1'b0;
      exp_sec          = 20'h00000;
      miscompares      = 0;
      tests_run        = 0;
      repeat (6) @(negedge clk_sys);
      rst_b = 1'b1;
      for (int i = 0; i < 9; i++) begin
         @(negedge clk_sys);
         ext_mode_req = rows[i].mode;
         send(rows[i].tgt, rows[i].data);
         wait_rd();
         if (rows[i].rd) check("rd_word", rd_word, rows[i].rexp);
         repeat (8) @(negedge clk_sys);
         case (rows[i].tgt)
            PSCP_TGT_PRIMARY: exp_sec = rows[i].exp;
            PSCP_TGT_STAGING: check("staging_word", staging_word, rows[i].exp);
            default: check("ext_word_eff", {12'h000, ext_word_eff}, rows[i].exp);
         endcase
         check("secondary_word", secondary_word, exp_sec);
      end
      // fill the queue until refused, then drain
      acc = 0;
      rdn = 0;
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      while (cmd_ready === 1'b1 && acc < 20) begin
         cmd = '{PSCP_TGT_PRIMARY, 20'(acc + 1)};
         @(negedge clk_sys);
         acc++;
         if (rd_valid === 1'b1) rdn++;
      end
      cmd_valid = 1'b0;
      check("cmd_refused", {19'h00000, cmd_ready}, 20'h00000);
      for (int n = 0; n < 6000 && rdn < acc; n++) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1) rdn++;
      end
      repeat (8) @(negedge clk_sys);
      check("rd_count", 20'(rdn), 20'(acc));
      check("secondary_last", secondary_word, 20'(acc));
      check("busy_idle", {19'h00000, busy}, 20'h00000);
      for (int k = 3; k >= 0; k--) begin
         {phase_up_pulse, phase_down_pulse} = 2'(k);
         repeat (80) @(negedge clk_sys);
         check("lock_pins", {16'h0000, lock_filter_node, locked, lnk.lock_indicator, lock_seen},
               {16'h0000, {4{k != 3}}});
      end
      for (int k = 0; k < 2; k++) begin
         freq_reg_select_req      = k[0];
         nv_select_req = k[0];
         repeat (10) @(negedge clk_sys);
         check("select_lines", {18'h00000, freq_sel_applied, nv_select_level},
               {18'h00000, k[0], k[0]});
      end
      // second reset in mid-run
      rst_b = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("reset_words", secondary_word | staging_word | {12'h000, ext_word_eff},
            20'h00000);
      check("reset_flags", {16'h0000, lnk.lock_indicator, nv_select_level, cmd_ready, busy},
            20'h00006);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      final_report();
   end
endmodule
`default_nettype wire
